// file: hcc_top.sv
// Command interpreter of a cascadable 64-bit CAM behind a 16-bit bus.
// Assumes the host strobes cycles with chip enable slower than four
// clocks per phase; all bus pins are asynchronous to clock.
`timescale 1ns/1ns
module hcc_top #(
   parameter int DEPTH = 16  // Entries, a power of two
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // Control bus
   input  wire logic        chip_enable_n,
   input  wire logic        write_n,
   input  wire logic        command_sel_n,
   input  wire logic        chain_enable_n,
   // Data lines
   input  wire logic [15:0] data_io_in,
   output logic      [15:0] data_io_out,
   output logic             data_io_oe,
   // Daisy chain and flags
   input  wire logic        chained_match_in_n,
   input  wire logic        chained_full_in_n,
   output logic             chained_match_out_n,
   output logic             chained_full_out_n,
   output logic             local_match_n,
   output logic             multi_match_n
);
   localparam int AW = $clog2(DEPTH);

   hcc_pkg::hcc_st_t r, n;          // State and next state
   logic [63:0]      mem [DEPTH];   // Entry storage
   logic [DEPTH-1:0] vld;           // Entry valid bits
   logic             mem_we, mem_clr;
   logic [AW-1:0]    mem_a;
   logic [63:0]      mem_d;
   hcc_pkg::hcc_set_t cur;          // Active register set
   logic             fall, rise, cmdwr, rsel, wsel;
   logic             mfdis, ffdis, full, iq;
   logic [15:0]      d;             // Captured bus data
   hcc_pkg::hcc_op_t dop;           // Opcode on the bus
   logic [DEPTH-1:0] hitv;          // Per-entry match
   logic [AW-1:0]    hp, nf;        // Priority match and next free

   // Edge detect and decode
   assign cur   = r.rs[r.bg];
   assign d     = r.s2.d;
   assign fall  = r.e_d & ~r.s2.e;
   assign rise  = ~r.e_d & r.s2.e;
   assign cmdwr = fall & ~r.s2.w & ~r.s2.cm;
   assign dop   = hcc_pkg::hcc_op_t'(d[hcc_pkg::OP_LSB +: 4]);
   assign rsel  = r.ds == r.pa;
   assign wsel  = rsel | (r.ds == hcc_pkg::DS_ALL);
   assign mfdis = cur.ct[hcc_pkg::CT_MF +: 2] != hcc_pkg::FL_ON;
   assign ffdis = cur.ct[hcc_pkg::CT_FF +: 2] != hcc_pkg::FL_ON;
   assign full  = &vld;
   assign iq    = mfdis | ~r.hit;

   // Outputs straight from state
   assign data_io_out         = r.dout;
   assign data_io_oe          = r.doe;
   assign chained_match_out_n = r.mf_n;
   assign chained_full_out_n  = r.ff_n;
   assign local_match_n       = r.ma_n;
   assign multi_match_n       = r.mm_n;

   // Masked compare, priority and next-free search
   always_comb begin : search
      logic [63:0] care;
      care = hcc_pkg::cam_mask(cur.ct[hcc_pkg::CT_PW +: 3]);
      if (cur.ct[hcc_pkg::CT_MS +: 2] == hcc_pkg::MS_M1)
         care = care & ~cur.mr1;
      else if (cur.ct[hcc_pkg::CT_MS +: 2] == hcc_pkg::MS_M2)
         care = care & ~r.mr2;
      hp = '0;
      nf = '0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         hitv[i] = vld[i] && (((mem[i] ^ r.cr) & care) == 64'h0);
         if (hitv[i]) hp = AW'(i);
         if (!vld[i]) nf = AW'(i);
      end
   end

   // Next-state logic
   always_comb begin : next_state
      logic             do_mem;
      logic             srst;
      hcc_pkg::hcc_op_t mop;
      logic [15:0]      madr;
      logic [15:0]      wd;
      logic [63:0]      src;
      logic [1:0]       sg;
      do_mem  = 1'b0;
      srst    = 1'b0;
      mop     = hcc_pkg::OP_NOP;
      madr    = cur.ar;
      wd      = hcc_pkg::xlat(d, cur.ct[hcc_pkg::CT_TR +: 2]
                              != hcc_pkg::TR_OFF);
      src     = r.cr;
      sg      = 2'h0;
      n       = r;
      mem_we  = 1'b0;
      mem_a   = '0;
      mem_d   = r.cr;
      mem_clr = 1'b0;
      // Two-stage pin synchroniser
      n.s1 = '{chip_enable_n, write_n, command_sel_n, chain_enable_n,
               chained_match_in_n, chained_full_in_n, data_io_in};
      n.s2 = r.s1;
      n.e_d = r.s2.e;
      // Flag pins
      n.ma_n = ~r.hit;
      n.mm_n = ~r.multi;
      n.mf_n = r.s2.ec | (r.s2.mi & iq);
      n.ff_n = ffdis ? r.s2.fi : (r.s2.fi | ~full);
      // Compare result
      if (r.cmp) begin
         n.cmp   = 1'b0;
         n.hit   = |hitv;
         n.multi = $countones(hitv) > 1;
         n.hpa   = 16'(hp);
         n.lock  = (cur.ct[hcc_pkg::CT_MD +: 2] == hcc_pkg::MD_STD)
                   && !(|hitv);
      end
      // Release the bus once chip enable is high
      if (r.s2.e) n.doe = 1'b0;
      // Segment counters step on the rising edge
      if (rise) begin
         if (r.adv_w)
            n.rs[r.bg].sc[hcc_pkg::SC_DST +: 2] =
               cur.sc[hcc_pkg::SC_DST +: 2] + 2'h1;
         if (r.adv_r)
            n.rs[r.bg].sc[hcc_pkg::SC_SRC +: 2] =
               cur.sc[hcc_pkg::SC_SRC +: 2] + 2'h1;
         n.adv_w = 1'b0;
         n.adv_r = 1'b0;
      end
      if (fall && r.s2.w) begin
         // Read cycle
         n.doe = rsel;
         if (!r.s2.cm) begin
            n.ovr_v = 1'b0;
            if (!r.ovr_v)
               n.dout = {r.pa[15-AW:0], r.hpa[AW-1:0]};
            else begin
               unique case (r.ovr)
                  hcc_pkg::TG_CT: n.dout = {1'b0, cur.ct[14:0]};
                  hcc_pkg::TG_PA: n.dout = r.pa;
                  hcc_pkg::TG_SC: n.dout = cur.sc;
                  hcc_pkg::TG_AR: n.dout = cur.ar;
                  hcc_pkg::TG_NF: begin
                     n.dout = 16'(nf);
                     n.dout[hcc_pkg::NF_FULL] = full;
                  end
                  hcc_pkg::TG_DS: n.dout = r.ds;
                  hcc_pkg::TG_PS: n.dout = 16'(cur.ps);
                  hcc_pkg::TG_PD: n.dout = 16'(cur.pd);
               endcase
            end
         end else begin
            unique case (cur.ps)
               hcc_pkg::RS_CR:  src = r.cr;
               hcc_pkg::RS_M1:  src = cur.mr1;
               hcc_pkg::RS_M2:  src = r.mr2;
               hcc_pkg::RS_MEM: src = mem[cur.ar[AW-1:0]];
            endcase
            sg = cur.sc[hcc_pkg::SC_SRC +: 2];
            n.dout  = src[int'(sg)*hcc_pkg::SEG_W +: 16];
            n.adv_r = rsel;
            if (rsel && cur.ps == hcc_pkg::RS_MEM
                && sg == hcc_pkg::SEG_LAST)
               n.rs[r.bg].ar = hcc_pkg::step(cur.ar,
                                  cur.ct[hcc_pkg::CT_AS +: 2]);
         end
      end else if (cmdwr) begin
         n.ovr_v = 1'b0;
         if (r.ovr_v) begin
            // One redirected command write
            if (r.ovr == hcc_pkg::TG_DS) n.ds = d;
            else if (wsel && !r.lock) begin
               unique case (r.ovr)
                  hcc_pkg::TG_CT: begin
                     if (!d[hcc_pkg::CT_RST]) srst = 1'b1;
                     else begin
                        n.rs[r.bg].ct = d;
                        n.cmp = 1'b1;
                     end
                  end
                  hcc_pkg::TG_PA: if (!ffdis) n.pa = d;
                  hcc_pkg::TG_SC: n.rs[r.bg].sc = d;
                  hcc_pkg::TG_AR: n.rs[r.bg].ar = d;
                  default: ;  // Next free and selections are read only
               endcase
            end
         end else if (r.af_v) begin
            // Second cycle loads the address and completes
            n.af_v = 1'b0;
            if (wsel) begin
               n.rs[r.bg].ar = d;
               do_mem = !r.lock;
               mop    = r.af_op;
               madr   = d;
            end
         end else if (wsel) begin
            // Instruction decoder
            if (d[hcc_pkg::INS_AF]) begin
               n.af_v  = 1'b1;
               n.af_op = dop;
            end else begin
               unique case (dop)
                  hcc_pkg::OP_NOP: n.lock = 1'b0;
                  hcc_pkg::OP_SPS:
                     n.rs[r.bg].ps = hcc_pkg::hcc_res_t'(d[1:0]);
                  hcc_pkg::OP_SPD:
                     n.rs[r.bg].pd = hcc_pkg::hcc_res_t'(d[1:0]);
                  hcc_pkg::OP_TCO: begin
                     n.ovr_v = 1'b1;
                     n.ovr   = hcc_pkg::hcc_tgt_t'(d[2:0]);
                  end
                  hcc_pkg::OP_SFG, hcc_pkg::OP_SBG: begin
                     n.bg    = dop == hcc_pkg::OP_SBG;
                     n.hit   = 1'b0;
                     n.multi = 1'b0;
                     n.lock  = 1'b0;
                  end
                  hcc_pkg::OP_MAR, hcc_pkg::OP_MHP,
                  hcc_pkg::OP_MNF: begin
                     do_mem = !r.lock;
                     mop    = dop;
                  end
                  default: ;  // Unused opcodes do nothing
               endcase
            end
         end
      end else if (fall && wsel && !r.lock) begin
         // Data write to the persistent destination
         sg = cur.sc[hcc_pkg::SC_DST +: 2];
         n.adv_w = 1'b1;
         unique case (cur.pd)
            hcc_pkg::RS_CR:  n.cr = hcc_pkg::seg_put(r.cr, sg, wd);
            hcc_pkg::RS_M1:
               n.rs[r.bg].mr1 = hcc_pkg::seg_put(cur.mr1, sg, wd);
            hcc_pkg::RS_M2:  n.mr2 = hcc_pkg::seg_put(r.mr2, sg, wd);
            hcc_pkg::RS_MEM: begin
               mem_we = 1'b1;
               mem_a  = cur.ar[AW-1:0];
               mem_d  = hcc_pkg::seg_put(mem[mem_a], sg, wd);
            end
         endcase
         if (sg == hcc_pkg::SEG_LAST) begin
            if (cur.pd == hcc_pkg::RS_MEM)
               n.rs[r.bg].ar = hcc_pkg::step(cur.ar,
                                  cur.ct[hcc_pkg::CT_AS +: 2]);
            else n.cmp = 1'b1;
         end
      end
      // Comparand moves into memory
      if (do_mem) begin
         unique case (mop)
            hcc_pkg::OP_MAR: begin
               mem_we = 1'b1;
               mem_a  = madr[AW-1:0];
               n.rs[r.bg].ar = hcc_pkg::step(madr,
                                  cur.ct[hcc_pkg::CT_AS +: 2]);
            end
            hcc_pkg::OP_MHP: begin
               mem_we = !mfdis && r.hit;
               mem_a  = r.hpa[AW-1:0];
            end
            hcc_pkg::OP_MNF: begin
               mem_we = !ffdis && !full;
               mem_a  = nf;
            end
            default: ;  // Deferred non-memory opcodes do nothing
         endcase
      end
      // Device reset by config write or reset pin
      if (srst || !reset_n) begin
         n.rs    = {2{hcc_pkg::SET_INIT}};
         n.bg    = 1'b0;
         n.cr    = 64'h0;
         n.mr2   = 64'h0;
         n.ovr_v = 1'b0;
         n.af_v  = 1'b0;
         n.hit   = 1'b0;
         n.multi = 1'b0;
         n.lock  = 1'b0;
         n.cmp   = 1'b0;
         mem_clr = 1'b1;
      end
      if (!reset_n) begin
         n.s1   = hcc_pkg::PIN_IDLE;
         n.s2   = hcc_pkg::PIN_IDLE;
         n.e_d  = 1'b1;
         n.pa   = 16'h0000;
         n.ds   = 16'h0000;
         n.hpa  = 16'h0000;
         n.dout = 16'h0000;
         n.doe  = 1'b0;
         n.adv_w = 1'b0;
         n.adv_r = 1'b0;
         n.ovr   = hcc_pkg::TG_CT;
         n.af_op = hcc_pkg::OP_NOP;
         {n.mf_n, n.ff_n, n.ma_n, n.mm_n} = 4'hF;
      end
   end

   // State register
   always_ff @(posedge clock) begin
      r <= n;
   end

   // Entry storage
   always_ff @(posedge clock) begin
      if (mem_we) mem[mem_a] <= mem_d;
      if (mem_clr) vld <= '0;
      else if (mem_we) vld[mem_a] <= 1'b1;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   AST_DS_WRITE: assert property (
      cmdwr && r.ovr_v && r.ovr == hcc_pkg::TG_DS |=> r.ds == $past(d))
      else $error("Device select write lost");
   AST_RD_SELECT: assert property (
      $rose(data_io_oe) |-> $past(rsel) && $past(r.s2.w))
      else $error("Read driven while deselected");
   AST_OE_LOW: assert property (
      data_io_oe |-> !$past(r.s2.e))
      else $error("Data driven with chip enable high");
   AST_OVR_ONE: assert property (
      fall && !r.s2.cm && r.ovr_v |=> !r.ovr_v)
      else $error("Override lasted past one cycle");
   AST_CT_RESET: assert property (
      cmdwr && r.ovr_v && r.ovr == hcc_pkg::TG_CT && wsel && !r.lock
      && !d[hcc_pkg::CT_RST] |=> cur.ct == hcc_pkg::CT_INIT && !r.cmp)
      else $error("Config reset not applied");
   AST_CT_CMP: assert property (
      cmdwr && r.ovr_v && r.ovr == hcc_pkg::TG_CT && wsel && !r.lock
      && d[hcc_pkg::CT_RST] |=> r.cmp ##1 !r.cmp)
      else $error("Config write gave no compare");
   AST_AF: assert property (
      cmdwr && !r.ovr_v && !r.af_v && wsel && d[hcc_pkg::INS_AF]
      |=> r.af_v)
      else $error("Address field not deferred");
   AST_MF_COPY: assert property (
      mfdis && !r.s2.ec |=> chained_match_out_n == $past(r.s2.mi))
      else $error("Match chain not copied");
   AST_FF_COPY: assert property (
      ffdis |=> chained_full_out_n == $past(r.s2.fi))
      else $error("Full chain not copied");
   AST_SWITCH: assert property (
      cmdwr && !r.ovr_v && !r.af_v && wsel && !d[hcc_pkg::INS_AF]
      && (dop == hcc_pkg::OP_SFG || dop == hcc_pkg::OP_SBG)
      |=> !r.hit ##1 local_match_n)
      else $error("Set switch kept match");
   AST_SEG: assert property (
      rise && r.adv_w |=> cur.sc[1:0] == $past(cur.sc[1:0]) + 2'h1)
      else $error("Destination segment did not advance");
endmodule : hcc_top

// file: hcc_pkg.sv
// Constants, encodings, helper functions and state types for the CAM
// host command controller.
// Assumes one 10 MHz clock and a 16-bit multiplexed command/data bus.
//
// Behaviour
// - Page address forms upper match address bits
// - Device select picks one device, all-ones picks all for writes
// - 64-bit resources move in four 16-bit segments
// - Low chain enable enables chained match output
// - Data cycles default to the comparand
// - Select instructions set persistent source and destination
// - Override readback returns persistent selection
// - Command writes decode, command reads return status
// - Override redirects only the next command cycle
// - Writes captured at fall, destination counter at rise
// - Reads captured at fall, driven low, counted rise
// - Foreground/background sets, foreground after reset
// - Config or last-segment register writes start a compare
// - Address-field flag defers instruction one write
// - Address steps per config bits 3 and 2
// - Config bit 15 low resets, reads zero
// - Match flag disable forces qualifier, copies chain
// - Full flag disable acts full, copies chain
// - Config bits 10 and 9 enable translation
// - Config bits 8 to 6 set CAM width
// - Config bits 5 and 4 select compare mask
// - Standard mode needs no-op unlock after miss
// - Deselect on mismatch, all-ones writes only
// - Set switch clears the match condition
package hcc_pkg;
   // Device select value that reaches every chained device on writes
   localparam logic [15:0] DS_ALL   = 16'hFFFF;
   // Config field positions, each field two bits unless noted
   localparam int CT_RST  = 15;  // Run bit, low means reset
   localparam int CT_MF   = 13;  // Match flag enable
   localparam int CT_FF   = 11;  // Full flag enable
   localparam int CT_TR   = 9;   // Translation enable
   localparam int CT_PW   = 6;   // Partition, three bits
   localparam int CT_MS   = 4;   // Compare mask select
   localparam int CT_AS   = 2;   // Address step
   localparam int CT_MD   = 0;   // Operating mode
   // Instruction fields
   localparam int INS_AF  = 11;  // Address field flag
   localparam int OP_LSB  = 12;  // Opcode field, four bits
   // Segment control counter positions
   localparam int SC_DST  = 0;
   localparam int SC_SRC  = 8;
   // Next-free readback full flag position
   localparam int NF_FULL = 15;
   localparam int SEG_W   = 16;
   localparam logic [1:0]  SEG_LAST = 2'h3;
   // Reset values
   localparam logic [15:0] CT_INIT  = 16'h0000;
   localparam logic [15:0] SC_INIT  = 16'h0000;
   // Two-bit field codes
   localparam logic [1:0]  FL_ON    = 2'h0;
   localparam logic [1:0]  MS_M1    = 2'h1;
   localparam logic [1:0]  MS_M2    = 2'h2;
   localparam logic [1:0]  AS_INC   = 2'h1;
   localparam logic [1:0]  AS_DEC   = 2'h2;
   localparam logic [1:0]  MD_STD   = 2'h0;
   localparam logic [1:0]  TR_OFF   = 2'h0;
   // Partition codes: 1-3 RAM at top, 4-6 RAM at bottom
   localparam logic [2:0]  PW_TOP   = 3'h3;
   localparam logic [2:0]  PW_BOT   = 3'h6;
   // Instruction opcodes
   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_SPS = 4'h1, OP_SPD = 4'h2, OP_TCO = 4'h3,
      OP_SFG = 4'h4, OP_SBG = 4'h5, OP_MAR = 4'h6, OP_MHP = 4'h7,
      OP_MNF = 4'h8
   } hcc_op_t;
   // Persistent 64-bit resources
   typedef enum logic [1:0] {
      RS_CR = 2'h0, RS_M1 = 2'h1, RS_M2 = 2'h2, RS_MEM = 2'h3
   } hcc_res_t;
   // One-shot override targets
   typedef enum logic [2:0] {
      TG_CT = 3'h0, TG_PA = 3'h1, TG_SC = 3'h2, TG_AR = 3'h3,
      TG_NF = 3'h4, TG_DS = 3'h5, TG_PS = 3'h6, TG_PD = 3'h7
   } hcc_tgt_t;
   // Synchronised pin group
   typedef struct packed {
      logic e, w, cm, ec, mi, fi;
      logic [15:0] d;
   } hcc_pin_t;
   // One switchable register set
   typedef struct packed {
      logic [15:0] ct, sc, ar;
      logic [63:0] mr1;
      hcc_res_t    ps, pd;
   } hcc_set_t;
   // Whole controller state
   typedef struct packed {
      hcc_pin_t       s1, s2;
      logic           e_d, bg, ovr_v, af_v, adv_w, adv_r, cmp;
      hcc_set_t [1:0] rs;
      logic [63:0]    cr, mr2;
      logic [15:0]    pa, ds, hpa, dout;
      hcc_tgt_t       ovr;
      hcc_op_t        af_op;
      logic           hit, multi, lock, doe, mf_n, ff_n, ma_n, mm_n;
   } hcc_st_t;
   localparam hcc_pin_t PIN_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
                                     1'b1, 16'h0000};
   localparam hcc_set_t SET_INIT = '{CT_INIT, SC_INIT, 16'h0000,
                                     64'h0, RS_CR, RS_CR};
   // Replace one 16-bit segment of a word
   function automatic logic [63:0] seg_put(logic [63:0] w,
                                          logic [1:0] s, logic [15:0] v);
      seg_put = w;
      seg_put[int'(s)*SEG_W +: SEG_W] = v;
   endfunction : seg_put
   // Reverse bit order inside each byte when enabled
   function automatic logic [15:0] xlat(logic [15:0] v, logic on);
      xlat = v;
      for (int i = 0; i < 8; i++) begin
         if (on) begin
            xlat[i] = v[7-i];
            xlat[8+i] = v[15-i];
         end
      end
   endfunction : xlat
   // Bits that take part in a compare for a partition code
   function automatic logic [63:0] cam_mask(logic [2:0] pw);
      cam_mask = '1;
      if (pw != 3'h0 && pw <= PW_TOP)
         cam_mask = cam_mask >> (int'(pw) * SEG_W);
      else if (pw > PW_TOP && pw <= PW_BOT)
         cam_mask = cam_mask << ((int'(pw) - int'(PW_TOP)) * SEG_W);
   endfunction : cam_mask
   // Address register step after a memory access
   function automatic logic [15:0] step(logic [15:0] a, logic [1:0] f);
      step = a;
      if (f == AS_INC) step = a + 16'h0001;
      else if (f == AS_DEC) step = a - 16'h0001;
   endfunction : step
endpackage : hcc_pkg

// file: hcc_host.sv
// Host and chain-neighbour model for the CAM command controller.
// Assumes the bench resolves the data bus from the device's output enable alone.
`timescale 1ns/1ns
module hcc_host (
   // Clock
   input  wire logic        clock,
   // Bus strobes and data
   output logic             chip_enable_n,
   output logic             write_n,
   output logic             command_sel_n,
   output logic [15:0]      data_io_in,
   // Neighbour chain pins
   output logic             chain_enable_n,
   output logic             chained_match_in_n,
   output logic             chained_full_in_n
);
   // Idle bus and chain at time zero
   initial begin
      chip_enable_n      = 1'b1;
      write_n            = 1'b1;
      command_sel_n      = 1'b1;
      data_io_in         = 16'h0000;
      chain_enable_n     = 1'b0;
      chained_match_in_n = 1'b1;
      chained_full_in_n  = 1'b1;
   end
   // One strobed cycle: pins settle 4 clocks before the fall, held 7
   task automatic cyc(input logic cm, input logic wr, input logic [15:0] d);
      @(posedge clock);
      command_sel_n <= cm;
      write_n       <= ~wr;
      data_io_in    <= wr ? d : ~data_io_in;
      repeat (4) @(posedge clock);
      chip_enable_n <= 1'b0;
      repeat (7) @(posedge clock);
      chip_enable_n <= 1'b1;
      repeat (7) @(posedge clock);
      // Released bus must not keep showing the old value
      data_io_in    <= ~data_io_in;
   endtask : cyc
   // Previous device's match flag
   task automatic set_mi(input logic m);
      @(posedge clock);
      chained_match_in_n <= m;
   endtask : set_mi
endmodule : hcc_host

// file: tb_top.sv
// Self-checking bench for the CAM host command controller.
// Assumes hcc_host drives the bus pins and hcc_top is the device.
`timescale 1ns/1ns
module tb_top;
   logic        clock, reset_n;               // Clock and reset
   logic        ce_n, w_n, cm_n, ec_n, mi_n, fi_n; // Host pins
   logic [15:0] host_dq, dq_in, dq_out;       // Bus lines
   logic        dq_oe, mo_n, fo_n, ma_n, mm_n, oe_d; // Device outputs
   logic [15:0] exp_q[$];                     // Expected read data
   logic [31:0] seed = 32'hAB9828DD;          // Random state
   logic [63:0] v;                            // Random test word
   int          num_errors = 0;
   int          n_compared = 0;
   // Device wins the bus while it drives
   assign dq_in = (dq_oe === 1'b1) ? dq_out : host_dq;
   hcc_host host (.clock(clock), .chip_enable_n(ce_n), .write_n(w_n),
      .command_sel_n(cm_n), .data_io_in(host_dq), .chain_enable_n(ec_n),
      .chained_match_in_n(mi_n), .chained_full_in_n(fi_n));
   hcc_top #(.DEPTH(4)) uut (.clock(clock), .reset_n(reset_n),
      .chip_enable_n(ce_n), .write_n(w_n), .command_sel_n(cm_n),
      .chain_enable_n(ec_n), .data_io_in(dq_in), .data_io_out(dq_out),
      .data_io_oe(dq_oe), .chained_match_in_n(mi_n),
      .chained_full_in_n(fi_n), .chained_match_out_n(mo_n),
      .chained_full_out_n(fo_n), .local_match_n(ma_n),
      .multi_match_n(mm_n));
   // 100 ns clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic check(input string n, input logic [15:0] s,
                        input logic [15:0] e);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask : check
   task automatic results;
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results
   // Bus cycle wrappers; reads leave a note for the monitor
   task automatic cw(input logic [15:0] d);
      host.cyc(1'b0, 1'b1, d);
   endtask : cw
   task automatic rd(input logic cm, input logic [15:0] e);
      exp_q.push_back(e);
      host.cyc(cm, 1'b0, 16'h0000);
   endtask : rd
   task automatic wr64(input logic [63:0] x);
      for (int i = 0; i < 4; i++) host.cyc(1'b1, 1'b1, x[16*i +: 16]);
   endtask : wr64
   task automatic rd64(input logic [63:0] x);
      for (int i = 0; i < 4; i++) rd(1'b1, x[16*i +: 16]);
   endtask : rd64
   // Takes the oldest note when the device starts driving the bus
   always @(negedge clock) begin
      oe_d <= dq_oe;
      if (dq_oe === 1'b1 && oe_d !== 1'b1) begin
         if (exp_q.size() == 0) check("stray read", 16'h0001, 16'h0000);
         else check("read", dq_out, exp_q.pop_front());
      end
   end
   // Hang guard, well past the roughly 1300 clocks the tests need
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      $display("[ERR] watchdog exp done seen hang");
      results();
   end
   // Main sequence
   initial begin
      reset_n = 1'b0;
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      #1 check("flags", {12'h000, mo_n, fo_n, ma_n, mm_n}, 16'h000F);
      seed = xs(seed);
      v[31:0] = seed;
      seed = xs(seed);
      v[63:32] = seed;
      // Enhanced mode, address increments; bit 15 reads as zero
      cw(16'h3000);
      cw(16'h8005);
      cw(16'h3000);
      rd(1'b0, 16'h0005);
      $display("Test config done");
      wr64(v);
      rd64(v);
      // Deferred move to address 2, then a matching compare
      cw(16'h6800);
      cw(16'h0002);
      // Plain move at the stepped address gives a second equal entry
      cw(16'h6000);
      wr64(v);
      #1 check("match", {15'h0, ma_n}, 16'h0000);
      check("chain out", {15'h0, mo_n}, 16'h0000);
      check("multi", {15'h0, mm_n}, 16'h0000);
      rd(1'b0, 16'h0002);
      cw(16'h1003);
      cw(16'h3003);
      cw(16'h0002);
      rd64(v);
      cw(16'h3003);
      rd(1'b0, 16'h0003);
      cw(16'h3006);
      rd(1'b0, 16'h0003);
      cw(16'h1000);
      $display("Test data done");
      // Background set clears the match and has its own config
      cw(16'h5000);
      #1 check("bg clear", {15'h0, ma_n}, 16'h0001);
      cw(16'h3000);
      rd(1'b0, 16'h0000);
      cw(16'h3000);
      cw(16'hB800);
      // Page address write is refused while the full flag is disabled
      cw(16'h3001);
      cw(16'h0005);
      host.set_mi(1'b0);
      repeat (6) @(posedge clock);
      #1 check("mf copy", {15'h0, mo_n}, 16'h0000);
      host.set_mi(1'b1);
      repeat (6) @(posedge clock);
      #1 check("mf copy", {15'h0, mo_n}, 16'h0001);
      cw(16'h4000);
      cw(16'h3000);
      rd(1'b0, 16'h0005);
      $display("Test sets done");
      // All-devices select accepts writes, refuses reads
      cw(16'h3005);
      cw(16'hFFFF);
      cw(16'h3001);
      cw(16'h0001);
      host.cyc(1'b0, 1'b0, 16'h0000);
      cw(16'h3005);
      cw(16'h0001);
      rd(1'b0, 16'h0006);
      cw(16'h3000);
      rd(1'b0, 16'h0005);
      $display("Test select done");
      // Soft reset leaves standard mode: a miss locks writes until no-op
      cw(16'h3000);
      cw(16'h0000);
      cw(16'h3000);
      rd(1'b0, 16'h0000);
      wr64(v);
      host.cyc(1'b1, 1'b1, ~v[15:0]);
      rd64(v);
      cw(16'h0000);
      host.cyc(1'b1, 1'b1, ~v[15:0]);
      rd(1'b1, ~v[15:0]);
      repeat (4) @(posedge clock);
      check("pending", 16'(exp_q.size()), 16'h0000);
      $display("Test reset done");
      results();
   end
endmodule : tb_top
